// File: inc/aol_defines.svh
`ifndef AOL_DEFINES_SVH
`define AOL_DEFINES_SVH

// byte offsets on the board bus
`define OFS_BOARD_ID 7'h00
`define OFS_CONTROL 7'h02
`define OFS_RESULT 7'h04
`define OFS_OUT_BASE 7'h40

// control and status word fields
`define BIT_SHORT_READY 15
`define BIT_LED_OFF 14
`define BIT_CONV 13
`define BIT_FORMAT 12
`define BIT_CONNECT 11
`define BIT_QUICK 8
`define BIT_SETTLE 6
`define BIT_HALT 5
`define CONTROL_RESET 16'h0000
// bits that software keeps: 14, 12, 11, 8, 5 and 4..0
`define CONTROL_KEEP_MASK 16'h593F

// arbitrary identity value, not tied to any product
`define BOARD_ID_VALUE 16'hA5C3

// timing in microseconds (quick refresh in nanoseconds), and clock rate in MHz
`define CLK_MHZ 200
`define SETTLE_LONG_US 5000
`define SETTLE_SHORT_US 3000
`define REFRESH_NORMAL_US 3400
`define REFRESH_QUICK_NS 850000
`define OUT_CHANNELS 32

`endif

// File: inc/aol_pkg.sv
package aol_pkg;

    // gray order along idle -> settle -> convert; convert -> idle flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONVERT = 2'b11
    } loop_state_t;

    typedef logic [15:0] word_t;

endpackage

// File: hw/output_sequencer.sv
`timescale 1ns/1ps

module output_sequencer #(
    parameter int unsigned SLOT_NORMAL_CYC = 21250,
    parameter int unsigned SLOT_QUICK_CYC = 5312
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic quick_i,
    output logic [4:0] slot_o,
    output logic step_o
);

    logic [23:0] count_reg;
    logic [23:0] slot_len;

    assign slot_len = quick_i ? SLOT_QUICK_CYC[23:0] : SLOT_NORMAL_CYC[23:0];

    // a mode change takes effect at the next slot boundary or sooner
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= 24'h000000;
        end else if (!run_i) begin
            count_reg <= 24'h000000;
        end else if (count_reg + 24'h000001 >= slot_len) begin
            count_reg <= 24'h000000;
        end else begin
            count_reg <= count_reg + 24'h000001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 1'b0;
            slot_o <= 5'h00;
        end else begin
            step_o <= run_i && (count_reg + 24'h000001 >= slot_len);
            if (step_o) begin
                slot_o <= slot_o + 5'h01;
            end
        end
    end

endmodule

// File: hw/analog_output_loopback_control.sv
`timescale 1ns/1ps
`include "aol_defines.svh"

module analog_output_loopback_control
    import aol_pkg::*;
#(
    parameter int unsigned SETTLE_LONG_CYC = `SETTLE_LONG_US * `CLK_MHZ,
    parameter int unsigned SETTLE_SHORT_CYC = `SETTLE_SHORT_US * `CLK_MHZ,
    parameter int unsigned REFRESH_NORMAL_CYC = `REFRESH_NORMAL_US * `CLK_MHZ,
    parameter int unsigned REFRESH_QUICK_CYC = `REFRESH_QUICK_NS * `CLK_MHZ / 1000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bus_sel_i,
    input wire logic bus_wr_i,
    input wire logic [6:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    output logic [15:0] bus_rdata_o,
    output logic bus_ack_o,
    output logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [11:0] adc_data_i,
    output logic [4:0] loop_channel_sel_o,
    output logic loop_mux_enable_o,
    output logic outputs_connect_o,
    output logic format_select_o,
    output logic led_on_o,
    output logic [4:0] dac_chan_o,
    output logic [11:0] dac_code_o,
    output logic dac_load_o
);

    // each refresh time rounds down to whole slot lengths
    localparam int unsigned SLOT_NORMAL_CYC = REFRESH_NORMAL_CYC / `OUT_CHANNELS;
    localparam int unsigned SLOT_QUICK_CYC = REFRESH_QUICK_CYC / `OUT_CHANNELS;

    word_t control_reg;
    word_t result_reg;
    word_t out_code_mem [0:`OUT_CHANNELS-1];
    loop_state_t state_reg;
    loop_state_t state_next;
    logic [23:0] settle_cnt_reg;
    logic ready_reg;
    logic done_meta_reg;
    logic done_sync_reg;
    logic done_prev_reg;
    logic [11:0] data_meta_reg;
    logic [11:0] data_sync_reg;
    logic [4:0] seq_slot;
    logic seq_step;

    logic wr_en;
    logic rd_en;
    logic ctrl_wr;
    logic start_req;
    logic halt;
    logic offset_fmt;
    logic done_rise;
    logic hit_id;
    logic hit_ctrl;
    logic hit_result;
    logic hit_out;

    // offset binary keeps only the twelve code bits
    function automatic word_t retain_code(input word_t d, input logic offs);
        retain_code = offs ? {4'h0, d[11:0]} : d;
    endfunction

    // converter and dac work in offset binary; two's complement flips the msb
    function automatic logic [11:0] swap_msb(input logic [11:0] d, input logic offs);
        swap_msb = offs ? d : {~d[11], d[10:0]};
    endfunction

    // bit 0 of the byte offset never selects a word
    function automatic logic word_hit(input logic [6:0] a, input logic [6:0] ofs);
        word_hit = (a[6:1] == ofs[6:1]);
    endfunction

    assign wr_en = bus_sel_i && bus_wr_i;
    assign rd_en = bus_sel_i && !bus_wr_i;
    assign hit_id = word_hit(bus_addr_i, `OFS_BOARD_ID);
    assign hit_ctrl = word_hit(bus_addr_i, `OFS_CONTROL);
    assign hit_result = word_hit(bus_addr_i, `OFS_RESULT);
    assign hit_out = bus_addr_i[6];
    assign ctrl_wr = wr_en && hit_ctrl;
    assign halt = control_reg[`BIT_HALT];
    assign offset_fmt = control_reg[`BIT_FORMAT];
    assign done_rise = done_sync_reg && !done_prev_reg;

    // both strobes in one write, never while halted or already busy
    assign start_req = ctrl_wr && bus_wdata_i[`BIT_CONV] && bus_wdata_i[`BIT_SETTLE]
        && !bus_wdata_i[`BIT_HALT] && !halt && (state_reg == ST_IDLE);

    // control word: strobe and reserved bits are not stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_reg <= `CONTROL_RESET;
        end else if (ctrl_wr) begin
            control_reg <= bus_wdata_i & `CONTROL_KEEP_MASK;
        end
    end

    // converter done pin and data come from another domain
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
            done_prev_reg <= 1'b0;
            data_meta_reg <= 12'h000;
            data_sync_reg <= 12'h000;
        end else begin
            done_meta_reg <= adc_done_i;
            done_sync_reg <= done_meta_reg;
            done_prev_reg <= done_sync_reg;
            data_meta_reg <= adc_data_i;
            data_sync_reg <= data_meta_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_req) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (halt) begin
                    state_next = ST_IDLE;
                end else if (settle_cnt_reg <= 24'h000001) begin
                    state_next = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (halt || done_rise) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // settling length chosen by the strobed bit of the start write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_cnt_reg <= 24'h000000;
        end else if (start_req) begin
            if (bus_wdata_i[`BIT_SHORT_READY]) begin
                settle_cnt_reg <= SETTLE_SHORT_CYC[23:0];
            end else begin
                settle_cnt_reg <= SETTLE_LONG_CYC[23:0];
            end
        end else if (state_reg == ST_SETTLE && settle_cnt_reg != 24'h000000) begin
            settle_cnt_reg <= settle_cnt_reg - 24'h000001;
        end
    end

    // pulse the converter as settling ends
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_start_o <= 1'b0;
        end else begin
            adc_start_o <= (state_reg == ST_SETTLE) && (state_next == ST_CONVERT);
        end
    end

    // result capture with format applied at capture time
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg <= 16'h0000;
        end else if (state_reg == ST_CONVERT && done_rise && !halt) begin
            if (offset_fmt) begin
                result_reg <= {4'h0, data_sync_reg};
            end else begin
                result_reg <= {{4{~data_sync_reg[11]}}, ~data_sync_reg[11],
                    data_sync_reg[10:0]};
            end
        end
    end

    // a new start clears ready; capture sets it, and set wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_reg <= 1'b0;
        end else if (state_reg == ST_CONVERT && done_rise && !halt) begin
            ready_reg <= 1'b1;
        end else if (start_req) begin
            ready_reg <= 1'b0;
        end
    end

    // output codes; offset mode drops the upper nibble on the way in
    always_ff @(posedge clk_i) begin
        if (wr_en && hit_out) begin
            out_code_mem[bus_addr_i[5:1]] <= retain_code(bus_wdata_i, offset_fmt);
        end
    end

    // register reads answer one cycle after the access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 16'h0000;
            bus_ack_o <= 1'b0;
        end else begin
            bus_ack_o <= bus_sel_i;
            bus_rdata_o <= 16'h0000;
            if (rd_en) begin
                if (hit_out) begin
                    bus_rdata_o <= retain_code(out_code_mem[bus_addr_i[5:1]],
                        offset_fmt);
                end else if (hit_id) begin
                    bus_rdata_o <= `BOARD_ID_VALUE;
                end else if (hit_ctrl) begin
                    bus_rdata_o <= control_reg;
                    bus_rdata_o[`BIT_SHORT_READY] <= ready_reg;
                    bus_rdata_o[`BIT_CONV] <= state_reg != ST_IDLE;
                    bus_rdata_o[`BIT_SETTLE] <= state_reg == ST_SETTLE;
                end else if (hit_result) begin
                    bus_rdata_o <= result_reg;
                end
            end
        end
    end

    // pin-facing controls follow the stored control word, except the loopback mux enable, which is held high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loop_channel_sel_o <= 5'h00;
            loop_mux_enable_o <= 1'b1;
            outputs_connect_o <= 1'b0;
            format_select_o <= 1'b0;
            led_on_o <= 1'b1;
        end else begin
            loop_channel_sel_o <= control_reg[4:0];
            loop_mux_enable_o <= 1'b1;
            outputs_connect_o <= control_reg[`BIT_CONNECT];
            format_select_o <= offset_fmt;
            led_on_o <= !control_reg[`BIT_LED_OFF];
        end
    end

    // one slot per channel: 32 slots cover the refresh period rounded down to a multiple of 32 cycles
    output_sequencer #(
        .SLOT_NORMAL_CYC(SLOT_NORMAL_CYC),
        .SLOT_QUICK_CYC(SLOT_QUICK_CYC)
    ) u_sequencer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(!halt),
        .quick_i(control_reg[`BIT_QUICK]),
        .slot_o(seq_slot),
        .step_o(seq_step)
    );

    // dac takes offset binary, so two's complement codes are converted here
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dac_chan_o <= 5'h00;
            dac_code_o <= 12'h000;
            dac_load_o <= 1'b0;
        end else begin
            dac_load_o <= seq_step;
            if (seq_step) begin
                dac_chan_o <= seq_slot;
                dac_code_o <= swap_msb(out_code_mem[seq_slot][11:0], offset_fmt);
            end
        end
    end

endmodule

// File: verification/aol_checker.sv
`timescale 1ns/1ps
module aol_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bus_sel_i,
    input wire logic bus_wr_i,
    input wire logic [6:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic [15:0] bus_rdata_o,
    input wire logic bus_ack_o,
    input wire logic adc_start_o,
    input wire logic [4:0] loop_channel_sel_o,
    input wire logic loop_mux_enable_o,
    input wire logic outputs_connect_o,
    input wire logic format_select_o,
    input wire logic led_on_o,
    input wire logic [4:0] dac_chan_o,
    input wire logic dac_load_o
);
    logic ctl_wr;
    logic seen;
    logic [15:0] wd;
    logic [1:0] age;
    logic [4:0] last_chan;
    assign ctl_wr = bus_sel_i && bus_wr_i && bus_addr_i[6:1] == 6'h01;
    // age saturates at 2: registered outputs have settled by then
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd <= 16'h0000;
            age <= 2'h2;
        end else if (ctl_wr) begin
            wd <= bus_wdata_i;
            age <= 2'h0;
        end else if (age != 2'h2) begin
            age <= age + 2'h1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen <= 1'b0;
        end else if (dac_load_o) begin
            seen <= 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (dac_load_o) begin
            last_chan <= dac_chan_o;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ack; bus_sel_i |=> bus_ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("access not acknowledged");
    property p_rdata_idle; !bus_ack_o |-> bus_rdata_o == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside acknowledge");
    property p_mux; loop_mux_enable_o; endproperty
    a_mux: assert property (p_mux)
        else $error("loopback mux disabled");
    property p_led; age == 2'h2 |-> led_on_o == !wd[14]; endproperty
    a_led: assert property (p_led)
        else $error("indicator level wrong");
    property p_connect; age == 2'h2 |-> outputs_connect_o == wd[11]; endproperty
    a_connect: assert property (p_connect)
        else $error("output connection wrong");
    property p_format; age == 2'h2 |-> format_select_o == wd[12]; endproperty
    a_format: assert property (p_format)
        else $error("format select wrong");
    property p_chan; age == 2'h2 |-> loop_channel_sel_o == wd[4:0]; endproperty
    a_chan: assert property (p_chan)
        else $error("loopback channel wrong");
    property p_halt; age == 2'h2 && wd[5] |-> !dac_load_o && !adc_start_o; endproperty
    a_halt: assert property (p_halt)
        else $error("activity while halted");
    property p_start_pulse; adc_start_o |=> !adc_start_o; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("converter start longer than one cycle");
    property p_dac_step; dac_load_o && seen |-> dac_chan_o == last_chan + 5'h01; endproperty
    a_dac_step: assert property (p_dac_step)
        else $error("refresh channel skipped");
endmodule
bind analog_output_loopback_control aol_checker aol_checker_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i),
    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .bus_ack_o(bus_ack_o), .adc_start_o(adc_start_o), .loop_channel_sel_o(loop_channel_sel_o),
    .loop_mux_enable_o(loop_mux_enable_o), .outputs_connect_o(outputs_connect_o),
    .format_select_o(format_select_o), .led_on_o(led_on_o), .dac_chan_o(dac_chan_o),
    .dac_load_o(dac_load_o));

// File: verification/adc_model.sv
`timescale 1ns/1ps
module adc_model (
    input wire logic clk_i,
    input wire logic adc_start_i,
    input wire logic [11:0] code_i,
    input wire logic [5:0] delay_i,
    output logic adc_done_o,
    output logic [11:0] adc_data_o
);
    initial begin
        adc_done_o = 1'b0;
        adc_data_o = 12'h5A5;
        forever begin
            @(posedge clk_i);
            if (adc_start_i) begin
                repeat (delay_i) @(posedge clk_i);
                adc_data_o <= code_i;
                @(posedge clk_i);
                adc_done_o <= 1'b1;
                repeat (5) @(posedge clk_i);
                adc_done_o <= 1'b0;
            end else begin
                // junk outside a result window, toggled so nothing stale passes
                adc_data_o <= ~adc_data_o;
            end
        end
    end
endmodule

// File: verification/analog_output_loopback_control_bench.sv
`timescale 1ns/1ps
`include "aol_defines.svh"
module analog_output_loopback_control_bench import aol_pkg::*;;
    localparam int LONG = 50;
    localparam int SHORT = 30;
    localparam int NORM = 640;
    localparam int QUICK = 160;
    typedef struct {word_t exp; word_t mask;} note_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [6:0] addr = 7'h00;
    word_t wdata = 16'h0000;
    word_t rdata;
    logic ack, start, done, mux_en, connect, fmt, led, load;
    logic [11:0] adc_data, dac_code;
    logic [11:0] code = 12'h000;
    logic [4:0] chan_sel, dac_chan;
    logic [5:0] delay = 6'h00;
    note_t notes[$];
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 68;
    int since_go = 0;
    int settle_exp = 0;
    word_t v[32];
    analog_output_loopback_control #(.SETTLE_LONG_CYC(LONG), .SETTLE_SHORT_CYC(SHORT),
        .REFRESH_NORMAL_CYC(NORM), .REFRESH_QUICK_CYC(QUICK))
    analog_output_loopback_control_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_sel_i(sel),
        .bus_wr_i(wr), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .bus_ack_o(ack), .adc_start_o(start), .adc_done_i(done), .adc_data_i(adc_data),
        .loop_channel_sel_o(chan_sel), .loop_mux_enable_o(mux_en), .outputs_connect_o(connect),
        .format_select_o(fmt), .led_on_o(led), .dac_chan_o(dac_chan), .dac_code_o(dac_code),
        .dac_load_o(load));
    adc_model adc_model_inst (.clk_i(clk_i), .adc_start_i(start), .code_i(code),
        .delay_i(delay), .adc_done_o(done), .adc_data_o(adc_data));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // read: d is the expected word under mask m; write notes carry mask 0
    task automatic acc(input logic w, input logic [6:0] a, input word_t d, input word_t m);
        @(negedge clk_i);
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = w ? d : 16'h0000;
        notes.push_back('{d, w ? 16'h0000 : m});
        @(negedge clk_i);
        sel = 1'b0;
    endtask
    always @(posedge clk_i) begin
        note_t n;
        #1;
        if (ack === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.mask != 16'h0000) check(rdata & n.mask, n.exp);
        end
        if (start === 1'b1) check(since_go + 1, settle_exp);
        since_go++;
        if (sel && wr && addr == 7'h02 && wdata[13] && wdata[6]) since_go = 0;
    end
    task automatic sweep(input int period, input logic f);
        int n;
        logic [11:0] e;
        n = 0;
        while (!(load === 1'b1 && dac_chan == 5'h00) && n < 4000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (load === 1'b1) begin
                e = v[dac_chan][11:0];
                check(dac_code, f ? e : {~e[11], e[10:0]});
            end
        end while (!(load === 1'b1 && dac_chan == 5'h00) && n < 4000);
        check(n, (period / 32) * 32);
    endtask
    task automatic convert(input logic s, input logic f);
        logic [4:0] ch;
        word_t cw;
        ch = 5'($random(seed));
        code = 12'($random(seed));
        delay = 6'($random(seed));
        settle_exp = s ? SHORT : LONG;
        cw = {s, 1'b0, 1'b1, f, 1'b1, 4'h0, 1'b1, 1'b0, ch};
        acc(1'b1, 7'h02, cw, 16'h0000);
        acc(1'b0, 7'h02, 16'h2040 | (cw & 16'h593F), 16'hFFFF);
        check(chan_sel, ch);
        repeat (LONG + 80) @(posedge clk_i);
        acc(1'b0, 7'h02, 16'h8000 | (cw & 16'h593F), 16'hFFFF);
        acc(1'b0, 7'h04, f ? {4'h0, code} : {{5{~code[11]}}, code[10:0]}, 16'hFFFF);
    endtask
    initial begin
        int n;
        word_t d;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        check(led, 1'b1);
        check(connect, 1'b0);
        check(mux_en, 1'b1);
        acc(1'b0, 7'h02, 16'h0000, 16'hFFFF);
        acc(1'b0, 7'h00, `BOARD_ID_VALUE, 16'hFFFF);
        acc(1'b0, 7'h06, 16'h0000, 16'hFFFF);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = 16'($random(seed)) & 16'hDFBF;
            acc(1'b1, 7'h02, d, 16'h0000);
            acc(1'b0, 7'h02, d & 16'h593F, 16'hFFFF);
            check(led, !d[14]);
            check(connect, d[11]);
            check(fmt, d[12]);
        end
        $display("control test done");
        for (int f = 0; f < 2; f++) begin
            acc(1'b1, 7'h02, f ? 16'h1000 : 16'h0000, 16'h0000);
            for (int ch = 0; ch < 32; ch++) begin
                v[ch] = 16'($random(seed));
                acc(1'b1, 7'(64 + 2 * ch), v[ch], 16'h0000);
                acc(1'b0, 7'(64 + 2 * ch), f ? v[ch] & 16'h0FFF : v[ch], 16'hFFFF);
            end
        end
        sweep(NORM, 1'b1);
        acc(1'b1, 7'h02, 16'h1100, 16'h0000);
        sweep(QUICK, 1'b1);
        $display("output test done");
        acc(1'b1, 7'h02, 16'h1120, 16'h0000);
        repeat (2) @(posedge clk_i);
        n = 0;
        repeat (200) begin
            @(posedge clk_i);
            #1;
            if (load === 1'b1) n++;
        end
        check(n, 0);
        acc(1'b1, 7'h02, 16'h3160, 16'h0000);
        acc(1'b0, 7'h02, 16'h1120, 16'hFFFF);
        acc(1'b1, 7'h02, 16'h1100, 16'h0000);
        sweep(QUICK, 1'b1);
        acc(1'b1, 7'h02, 16'h0100, 16'h0000);
        sweep(QUICK, 1'b0);
        $display("halt test done");
        for (int k = 0; k < 4; k++) convert(k[0], k[1]);
        $display("loopback test done");
        end_of_test();
    end
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule
